// [src/cbo_pkg.sv]
// constants and types for the console button and output control block
package cbo_pkg;
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned DEBOUNCE_US    = 10;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned HOLD_MS        = 300;
   localparam int unsigned HOLD_CYC       = HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned GAIN_W         = 8;
   localparam logic [7:0]  GAIN_MAX       = 8'hff;
   localparam logic [7:0]  GAIN_MIN40     = 8'h03;
   localparam logic [7:0]  GAIN_MUTE      = 8'h00;
   localparam logic [7:0]  POS_CCW        = 8'h00;
   localparam logic [7:0]  POS_CW         = 8'hff;
   localparam logic [7:0]  POS_MID        = 8'h80;

   typedef enum logic [1:0] {
      CBO_MAIN_PTM = 2'b00,
      CBO_MAIN_PTT = 2'b01,
      CBO_MAIN_ALT = 2'b10,
      CBO_MAIN_HYB = 2'b11
   } cbo_main_mode_t;

   typedef enum logic [1:0] {
      CBO_BTN_IDLE = 2'b00,
      CBO_BTN_WAIT = 2'b01,
      CBO_BTN_HELD = 2'b10
   } cbo_btn_state_t;
endpackage

// [src/cbo_btn_if.sv]
// carries one conditioned button's level and events
`timescale 1ns/1ps
interface cbo_btn_if;
   logic down;    // debounced level
   logic press;   // pulse on debounced press
   logic tap;     // pulse on release before hold time
   logic held;    // level while press has passed hold time
   modport src (output down, press, tap, held);
   modport dst (input down, press, tap, held);
endinterface

// [src/cbo_btn_cond.sv]
// debouncer and tap/hold classifier for one pushbutton
`timescale 1ns/1ps
module cbo_btn_cond #(
   parameter int unsigned DEB_CYC  = cbo_pkg::DEBOUNCE_CYC,
   parameter int unsigned HOLD_CYC = cbo_pkg::HOLD_CYC
) (
   input wire logic  sys_clk,  // system clock
   input wire logic  rstn,     // async reset, active low
   input wire logic  raw,      // button pressed, active high
   cbo_btn_if.src    btn       // conditioned button
);
   logic [11:0]  deb_cnt;
   logic         stable;
   logic [27:0]  hold_cnt;
   cbo_pkg::cbo_btn_state_t state;

   wire differs   = raw != stable;
   wire deb_done  = deb_cnt >= 12'(DEB_CYC - 1);
   wire hold_done = hold_cnt >= 28'(HOLD_CYC - 1);
   wire rise      = differs && deb_done && raw;
   wire fall      = differs && deb_done && !raw;

   // input must stay changed for the whole window before it is believed
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         deb_cnt <= '0;
         stable  <= 1'b0;
      end else if (!differs || deb_done) begin
         deb_cnt <= '0;
         stable  <= differs ? raw : stable;
      end else begin
         deb_cnt <= deb_cnt + 12'h001;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state    <= cbo_pkg::CBO_BTN_IDLE;
         hold_cnt <= '0;
      end else begin
         unique case (state)
            cbo_pkg::CBO_BTN_IDLE: begin
               hold_cnt <= '0;
               if (rise) state <= cbo_pkg::CBO_BTN_WAIT;
            end
            cbo_pkg::CBO_BTN_WAIT: begin
               hold_cnt <= hold_cnt + 28'h0000001;
               if (fall) state <= cbo_pkg::CBO_BTN_IDLE;
               else if (hold_done) state <= cbo_pkg::CBO_BTN_HELD;
            end
            cbo_pkg::CBO_BTN_HELD: begin
               if (fall) state <= cbo_pkg::CBO_BTN_IDLE;
            end
            default: state <= cbo_pkg::CBO_BTN_IDLE;
         endcase
      end
   end

   assign btn.down  = stable;
   assign btn.press = rise;
   assign btn.tap   = fall && state == cbo_pkg::CBO_BTN_WAIT;
   assign btn.held  = state == cbo_pkg::CBO_BTN_HELD;
endmodule // cbo_btn_cond

// [src/cbo_top.sv]
// console button, indicator and headphone gain control
`timescale 1ns/1ps
module cbo_top #(
   parameter int unsigned DEB_CYC  = cbo_pkg::DEBOUNCE_CYC,
   parameter int unsigned HOLD_CYC = cbo_pkg::HOLD_CYC
) (
   input  wire logic        sys_clk,            // 250 MHz clock
   input  wire logic        rstn,               // async reset, active low
   input  wire logic        main_output_button, // main button, high pressed
   input  wire logic        tb1_button,         // talkback one button
   input  wire logic        tb2_button,         // talkback two button
   input  wire logic [1:0]  main_mode,          // cbo_main_mode_t code
   input  wire logic        main_force_off,     // 1 force-off, 0 normal
   input  wire logic        tb1_hybrid,         // 1 hybrid, 0 push-to-talk
   input  wire logic        tb2_hybrid,         // 1 hybrid, 0 push-to-talk
   input  wire logic        tb2_enable,         // talkback two function on
   input  wire logic        relay_follow_tb2,   // relay follows button two
   input  wire logic        on_air,             // 1 on-air, 0 production
   input  wire logic        hp_balance,         // 1 level/balance mode
   input  wire logic        hp_reverse,         // swap left and right
   input  wire logic        hp_full_mute,       // 1 full mute, 0 minus 40
   input  wire logic [7:0]  pot_left,           // left control, 0 = ccw
   input  wire logic [7:0]  pot_right,          // right control, 0 = ccw
   output logic             main_active,        // main output active
   output logic             tb1_active,         // talkback one active
   output logic             tb2_active,         // talkback two active
   output logic             relay_on,           // auxiliary relay drive
   output logic             led_main_green,     // main active lamp
   output logic             led_main_red,       // main muted lamp
   output logic             led_tb1,            // talkback one lamp
   output logic             led_tb2,            // talkback two lamp
   output logic [7:0]       hp_gain_left,       // left headphone gain
   output logic [7:0]       hp_gain_right       // right headphone gain
);
   cbo_btn_if b_main();
   cbo_btn_if b_tb1();
   cbo_btn_if b_tb2();

   cbo_btn_cond #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_main (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .raw     (main_output_button),
      .btn     (b_main)
   );
   cbo_btn_cond #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_tb1 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .raw     (tb1_button),
      .btn     (b_tb1)
   );
   cbo_btn_cond #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_tb2 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .raw     (tb2_button),
      .btn     (b_tb2)
   );

   logic main_latch;
   logic tb1_latch;
   logic tb2_latch;

   // talkback lines
   wire tb1_now = tb1_hybrid ? (tb1_latch || b_tb1.held)
                             : b_tb1.down;
   wire tb2_now = tb2_hybrid ? (tb2_latch || b_tb2.held)
                             : b_tb2.down;
   wire tb2_func = tb2_enable && tb2_now;
   wire talk_any = tb1_now || tb2_func;
   wire mode_alt = main_mode == cbo_pkg::CBO_MAIN_ALT;
   wire mode_hyb = main_mode == cbo_pkg::CBO_MAIN_HYB;
   wire interplay = on_air && (mode_alt || mode_hyb);

   // button-only main state before talkback muting
   logic main_btn;
   always_comb begin
      unique case (cbo_pkg::cbo_main_mode_t'(main_mode))
         cbo_pkg::CBO_MAIN_PTM: main_btn = !b_main.down;
         cbo_pkg::CBO_MAIN_PTT: main_btn = b_main.down;
         cbo_pkg::CBO_MAIN_ALT: main_btn = main_latch;
         cbo_pkg::CBO_MAIN_HYB:
            main_btn = main_latch || b_main.held;
      endcase
   end
   // on-air muting covers every main mode; production ignores talkback
   wire next_main = main_btn
                    && !(on_air && talk_any);

   // presses during talkback toggle the latch unless on-air force-off clears it; it shows when talk ends
   wire main_toggle = mode_alt ? b_main.press : (mode_hyb && b_main.tap);
   wire force_clr   = interplay && main_force_off && talk_any;

   // clear beats a same-cycle toggle so force-off can never re-latch
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         main_latch <= 1'b0;
      end else begin
         main_latch <= force_clr ? 1'b0
                       : main_latch ^ main_toggle;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tb1_latch <= 1'b0;
      end else begin
         tb1_latch <= tb1_latch ^ (tb1_hybrid && b_tb1.tap);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tb2_latch <= 1'b0;
      end else begin
         tb2_latch <= tb2_latch ^ (tb2_hybrid && b_tb2.tap);
      end
   end

   // headphone gain mapping
   wire [7:0] floor_g = hp_full_mute ? cbo_pkg::GAIN_MUTE
                                     : cbo_pkg::GAIN_MIN40;
   function automatic logic [7:0] pot_gain(input logic [7:0] pos,
                                           input logic [7:0] flr);
      pot_gain = (pos == cbo_pkg::POS_CCW) ? flr
               : ((pos < flr) ? flr : pos);
   endfunction
   // balance scale: cut one side linearly toward its extreme
   function automatic logic [7:0] bal_gain(input logic [7:0] lvl,
                                           input logic [7:0] off,
                                           input logic [7:0] flr);
      logic [15:0] prod;
      logic [7:0]  g;
      prod = lvl * (cbo_pkg::GAIN_MAX - off);
      g    = prod[15:8];
      bal_gain = (off == cbo_pkg::POS_CW) ? flr
               : ((g < flr) ? flr : g);
   endfunction

   wire [7:0] lvl_l = pot_gain(pot_left, floor_g);
   wire [7:0] lvl_r = pot_gain(pot_right, floor_g);
   // ccw distance below centre cuts one side, cw distance the other
   wire [7:0] ccw_off = (pot_right < cbo_pkg::POS_MID)
      ? 8'((cbo_pkg::POS_MID - pot_right) << 1) : 8'h00;
   wire [7:0] cw_off  = (pot_right > cbo_pkg::POS_MID)
      ? ((pot_right == cbo_pkg::POS_CW) ? cbo_pkg::POS_CW
         : 8'((pot_right - cbo_pkg::POS_MID) << 1)) : 8'h00;
   wire [7:0] ccw_eff = (pot_right == cbo_pkg::POS_CCW) ? cbo_pkg::POS_CW
                                                        : ccw_off;
   wire [7:0] bal_a   = bal_gain(lvl_l, ccw_eff, floor_g);
   wire [7:0] bal_b   = bal_gain(lvl_l, cw_off, floor_g);
   // normal: ccw cuts right; reverse: ccw cuts left
   wire [7:0] next_l = hp_balance ? (hp_reverse ? bal_a : bal_b)
                                  : (hp_reverse ? lvl_r : lvl_l);
   wire [7:0] next_r = hp_balance ? (hp_reverse ? bal_b : bal_a)
                                  : (hp_reverse ? lvl_l : lvl_r);

   // lamp and relay next values
   // production: main acts as a plain talk output, so red stays dark
   wire next_red      = on_air && !next_main;
   wire next_relay    = relay_follow_tb2 && b_tb2.down;
   // disabled function leaves the lamp to show the relay
   wire next_tb2_lamp = tb2_enable ? tb2_now : next_relay;

   // one short register per output keeps each reset value in plain view
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         main_active <= 1'b0;
      end else begin
         main_active <= next_main;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tb1_active <= 1'b0;
      end else begin
         tb1_active <= tb1_now;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tb2_active <= 1'b0;
      end else begin
         tb2_active <= tb2_func;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         relay_on <= 1'b0;
      end else begin
         relay_on <= next_relay;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         led_main_green <= 1'b0;
      end else begin
         led_main_green <= next_main;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         led_main_red <= 1'b0;
      end else begin
         led_main_red <= next_red;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         led_tb1 <= 1'b0;
      end else begin
         led_tb1 <= tb1_now;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         led_tb2 <= 1'b0;
      end else begin
         led_tb2 <= next_tb2_lamp;
      end
   end

   // gains sit at mute through reset so nothing leaks at power-up
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         hp_gain_left <= cbo_pkg::GAIN_MUTE;
      end else begin
         hp_gain_left <= next_l;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         hp_gain_right <= cbo_pkg::GAIN_MUTE;
      end else begin
         hp_gain_right <= next_r;
      end
   end
endmodule // cbo_top

// [test/cbo_panel_model.sv]
// front panel model: pushbuttons whose contacts bounce
`timescale 1ns/1ps
module cbo_panel_model (
   input  wire logic       sys_clk, // panel sampling clock
   input  wire logic [2:0] want,    // requested button levels
   output logic      [2:0] raw      // contact levels seen by the block
);
   logic [2:0] want_d;
   logic [2:0] want_dd;
   // one bounce cycle after each change, shorter than any debounce
   always @(posedge sys_clk) begin
      want_d  <= want;
      want_dd <= want_d;
   end
   assign raw = want ^ want_d ^ want_dd;
endmodule // cbo_panel_model

// [test/cbo_top_asserts.sv]
// port-level checks for the console button and output block
`timescale 1ns/1ps
module cbo_top_asserts #(
   parameter int unsigned DEB_CYC  = 4,  // debounce length
   parameter int unsigned HOLD_CYC = 40  // tap or hold limit
) (
   input wire logic       sys_clk,        // clock
   input wire logic       rstn,           // reset, active low
   input wire logic       on_air,         // system mode
   input wire logic       hp_balance,     // level/balance
   input wire logic       hp_reverse,     // swap channels
   input wire logic       hp_full_mute,   // mute floor
   input wire logic [7:0] pot_left,       // left control
   input wire logic [7:0] pot_right,      // right control
   input wire logic       main_active,    // main state
   input wire logic       tb1_active,     // talkback one
   input wire logic       tb2_active,     // talkback two
   input wire logic       led_main_green, // main green
   input wire logic       led_main_red,   // main red
   input wire logic       led_tb1,        // lamp one
   input wire logic       led_tb2,        // lamp two
   input wire logic [7:0] hp_gain_left,   // left gain
   input wire logic [7:0] hp_gain_right   // right gain
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   function automatic logic [7:0] lvl(logic [7:0] p, logic fm);
      return (fm || p >= 8'h03) ? p : 8'h03;
   endfunction
   sequence s_tb_busy; on_air && (tb1_active || tb2_active); endsequence
   sequence s_main_cut; ##[0:1] !main_active; endsequence
   property p_green; main_active |-> ##[0:1] led_main_green; endproperty
   a_green: assert property (p_green) else $error("green lamp dark");
   // first edge after reset still shows reset values, so skip it
   property p_red_air; on_air && $past(on_air) && $past(rstn)
      && !main_active |-> led_main_red; endproperty
   a_red_air: assert property (p_red_air) else $error("red dark");
   property p_red_prod; !on_air && !$past(on_air) |-> !led_main_red;
   endproperty
   a_red_prod: assert property (p_red_prod) else $error("red lit");
   property p_tb_mute; s_tb_busy |-> s_main_cut; endproperty
   a_tb_mute: assert property (p_tb_mute) else $error("main live");
   property p_led_tb1; tb1_active |-> ##[0:1] led_tb1; endproperty
   a_led_tb1: assert property (p_led_tb1) else $error("lamp one");
   property p_led_tb2; tb2_active |-> ##[0:1] led_tb2; endproperty
   a_led_tb2: assert property (p_led_tb2) else $error("lamp two");
   property p_ll; !hp_balance |=> hp_gain_left == lvl($past(hp_reverse) ?
      $past(pot_right) : $past(pot_left), $past(hp_full_mute));
   endproperty
   a_ll: assert property (p_ll) else $error("level gain");
   property p_floor; !hp_full_mute |=> hp_gain_left != 8'h00
      && hp_gain_right != 8'h00; endproperty
   a_floor: assert property (p_floor) else $error("muted");
   property p_bal_cut; hp_balance && pot_right == 8'h00 |=> ($past(hp_reverse)
      ? hp_gain_left : hp_gain_right) == lvl(8'h00, $past(hp_full_mute));
   endproperty
   a_bal_cut: assert property (p_bal_cut) else $error("cut");
endmodule // cbo_top_asserts

// [test/cbo_top_tb.sv]
// self-checking bench for the console button and output block
`timescale 1ns/1ps
module cbo_top_tb;
   logic       sys_clk = 1'h0, rstn = 1'h0, main_force_off = 1'h0;
   wire logic  main_output_button, tb1_button, tb2_button;
   logic [1:0] main_mode = 2'h0;
   logic       tb1_hybrid = 1'h0, tb2_hybrid = 1'h0, tb2_enable = 1'h0;
   logic       relay_follow_tb2 = 1'h0, on_air = 1'h0, hp_balance = 1'h0;
   logic       hp_reverse = 1'h0, hp_full_mute = 1'h0, relay_on;
   logic [7:0] pot_left = 8'h00, pot_right = 8'h00, seen;
   logic       main_active, tb1_active, tb2_active;
   logic       led_main_green, led_main_red, led_tb1, led_tb2;
   logic [7:0] hp_gain_left, hp_gain_right;
   logic [2:0] want = 3'h0;
   wire  [2:1] act = {tb2_active, tb1_active};
   wire  [2:1] led = {led_tb2, led_tb1};
   int         miscompares = 0, samples_checked = 0, cyc = 0;
   // per mode: idle, held, after hold, after tap
   logic [3:0] tbl [4] = '{4'hb, 4'h4, 4'h6, 4'h5};
   logic [7:0] pv [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hff, 8'h80};
   cbo_top #(.DEB_CYC(4), .HOLD_CYC(40)) DUT (.*);
   cbo_panel_model panel (.sys_clk(sys_clk), .want(want),
      .raw({tb2_button, tb1_button, main_output_button}));
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rst();
      rstn = 1'h0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'h1;
      repeat (20) @(negedge sys_clk);
   endtask
   task automatic hold(int b, int n);
      want[b] = 1'h1;
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic rel(int b);
      want[b] = 1'h0;
      repeat (15) @(negedge sys_clk);
   endtask
   task automatic tap(int b);
      hold(b, 12);
      rel(b);
   endtask
   task automatic chk_main(logic e);
      chk("main_active", e, main_active);
      chk("led_main_green", e, led_main_green);
      chk("led_main_red", on_air & ~e, led_main_red);
   endtask
   function automatic logic [7:0] lvl(logic [7:0] p);
      return (hp_full_mute || p >= 8'h03) ? p : 8'h03;
   endfunction
   initial begin
      void'($urandom(92685));
      repeat (8) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         main_mode = 2'(i);
         on_air = i[2];
         rst();
         chk_main(tbl[i%4][3]);
         hold(0, 55);
         chk_main(tbl[i%4][2]);
         rel(0);
         chk_main(tbl[i%4][1]);
         tap(0);
         chk_main(tbl[i%4][0]);
      end
      $display("test button_modes done");
      main_mode = 2'h2;
      tb2_enable = 1'h1;
      for (int i = 0; i < 8; i++) begin
         {main_force_off, on_air} = 2'(i);
         rst();
         tap(0);
         hold(i[2] + 1, 30);
         chk("tb_active", 8'h01, act[i[2] + 1]);
         chk("led_tb", 8'h01, led[i[2] + 1]);
         chk_main(~on_air);
         rel(i[2] + 1);
         chk_main(~on_air | ~main_force_off);
      end
      $display("test talkback_interplay done");
      {tb1_hybrid, tb2_hybrid, on_air} = 3'h6;
      for (int b = 1; b < 3; b++) begin
         tap(b);
         chk("tb_tap_on", 8'h01, act[b]);
         tap(b);
         chk("tb_tap_off", 8'h00, act[b]);
         hold(b, 55);
         chk("tb_held", 8'h01, act[b]);
         rel(b);
         chk("tb_released", 8'h00, act[b]);
      end
      tb2_enable = 1'h0;
      for (int r = 0; r < 2; r++) begin
         relay_follow_tb2 = r[0];
         hold(2, 30);
         chk("tb2_active", 8'h00, tb2_active);
         chk("led_tb2", r[0], led_tb2);
         chk("relay_on", r[0], relay_on);
         rel(2);
      end
      $display("test talkback_modes done");
      for (int i = 0; i < 48; i++) begin
         {hp_reverse, hp_full_mute} = 2'($urandom);
         pot_left = i[0] ? pv[$urandom % 6] : 8'($urandom);
         pot_right = i[1] ? pv[$urandom % 6] : 8'($urandom);
         repeat (2) @(negedge sys_clk);
         seen = hp_reverse ? pot_right : pot_left;
         chk("hp_gain_left", lvl(seen), hp_gain_left);
         seen = hp_reverse ? pot_left : pot_right;
         chk("hp_gain_right", lvl(seen), hp_gain_right);
      end
      hp_balance = 1'h1;
      for (int i = 0; i < 8; i++) begin
         {hp_full_mute, hp_reverse} = 2'(i);
         {pot_left, pot_right} = {8'hc0, i[2] ? 8'hff : 8'h00};
         repeat (2) @(negedge sys_clk);
         seen = (i[2] == hp_reverse) ? hp_gain_right : hp_gain_left;
         chk("hp_gain_cut", lvl(8'h00), seen);
         pot_left = 8'h00;
         repeat (2) @(negedge sys_clk);
         chk("hp_gain_left", lvl(8'h00), hp_gain_left);
         chk("hp_gain_right", lvl(8'h00), hp_gain_right);
      end
      $display("test headphone_gain done");
      close_out();
   end
endmodule // cbo_top_tb
bind cbo_top cbo_top_asserts #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) chk_i (
   .sys_clk(sys_clk), .rstn(rstn), .on_air(on_air), .hp_balance(hp_balance),
   .hp_reverse(hp_reverse), .hp_full_mute(hp_full_mute),
   .pot_left(pot_left), .pot_right(pot_right), .main_active(main_active),
   .tb1_active(tb1_active), .tb2_active(tb2_active),
   .led_main_green(led_main_green), .led_main_red(led_main_red),
   .led_tb1(led_tb1), .led_tb2(led_tb2), .hp_gain_left(hp_gain_left),
   .hp_gain_right(hp_gain_right));
